// ### ux_uart_ext.v
// UART with nine-bit multidrop framing, protection, bus timeout and identity registers
`timescale 1ns/1ns
`default_nettype none
`include "ux_defs.vh"
module ux_uart_ext #(
	parameter BIT_CYCLES = `UX_BIT_CYCLES,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3,
	parameter hardcoded_timeout_option = 0,
	parameter TIMEOUT_DEFAULT = `UX_TO_RST,
	parameter param_register_present = 1,
	parameter FEATURES_PRESENT = 1,
	parameter [9:0] FEATURE_FLAGS = 10'h000,
	parameter [7:0] QUEUE_DEPTH_CODE = 8'h01,
	parameter [31:0] VERSION_VALUE = 32'h3130302A, // Arbitrary value
	parameter [31:0] TYPE_VALUE = 32'h5A5A0001 // Arbitrary value
) (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [2:0] pprot,
	output wire pready,
	output wire [31:0] prdata,
	output wire pslverr,
	input wire rxd,
	output wire txd
);
	// One-hot transmit and receive states
	localparam [1:0] S_IDLE = 2'b01;
	localparam [1:0] S_RUN = 2'b10;

	reg [3:0] line_ext_control; // Extended control fields
	reg [7:0] rx_address_value; // Receive match address
	reg [7:0] tx_address_value; // Transmit address byte
	reg [2:0] access_protection_level; // Required privilege bits
	reg [7:0] bus_timeout_reload; // Hang counter reload
	reg [7:0] to_cnt_reg; // Hang counter
	reg [31:0] prdata_reg; // Read data, captured in setup phase
	reg [8:0] rx_data_reg; // Last stored character
	reg rx_valid_reg; // Stored character not yet read
	reg rx_ovr_reg; // Character lost while one was waiting
	reg match_reg; // Address matched, data accepted

	// Decoded control fields
	wire nine_bit_enable = line_ext_control[`UX_LCR_NINE];
	wire tx_mode = line_ext_control[`UX_LCR_MODE];
	wire send_eff = nine_bit_enable & ~tx_mode & line_ext_control[`UX_LCR_SEND];
	wire filter_eff = nine_bit_enable & line_ext_control[`UX_LCR_MATCH];

	// Bus phases
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire prot_ok = ((pprot & access_protection_level) == access_protection_level);
	wire is_hold = (paddr == `UX_OFF_DATA) | (paddr == `UX_OFF_SHADOW);

	// Transmit queue interface
	wire q_in_ready;
	wire q_out_valid;
	wire [8:0] q_out_data;
	wire q_pop;
	wire hold_wr = access & pwrite & is_hold & prot_ok;
	wire stall = hold_wr & ~q_in_ready;
	wire timed_out = stall & (to_cnt_reg == 8'h00);
	wire done = access & (~stall | timed_out);
	wire [8:0] hold_data = tx_mode ? pwdata[8:0] : {1'b0, pwdata[7:0]};

	// Write strobe for register updates on the completing beat only
	wire wr_ok = done & pwrite & prot_ok;

	assign pready = ~access | ~stall | timed_out;
	assign pslverr = access & (timed_out | ~prot_ok);
	assign prdata = prdata_reg;

	// Transmit queue sits between the holding register and the shifter
	ux_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_tx_queue (
		.clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.in_valid(hold_wr & ~timed_out),
		.in_ready(q_in_ready),
		.in_data(hold_data),
		.out_valid(q_out_valid),
		.out_ready(q_pop),
		.out_data(q_out_data)
	);

	// Parameter word of queue depth code, feature flags and bus width code, masked off when the parameter register is absent
	function [31:0] param_word;
		input dummy;
		begin
			param_word = 32'h0;
			param_word[`UX_PAR_FIFO_LSB+7:`UX_PAR_FIFO_LSB] = QUEUE_DEPTH_CODE;
			param_word[`UX_PAR_FEAT_LSB+9:`UX_PAR_FEAT_LSB] = FEATURE_FLAGS;
			param_word[1:0] = `UX_PAR_BUS_32;
		end
	endfunction

	// Transmit shifter state
	reg [1:0] tx_state;
	reg [10:0] tx_sh_reg; // Stop, data, start
	reg [3:0] tx_bits_reg; // Bits left in the frame
	reg [15:0] tx_div_reg; // Bit period counter
	reg txd_reg;
	wire tx_start = (tx_state == S_IDLE) & (send_eff | q_out_valid);
	assign q_pop = (tx_state == S_IDLE) & ~send_eff & q_out_valid;
	assign txd = txd_reg;

	// Read mux; the status word shows the block's own activity
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0;
		case (paddr)
			`UX_OFF_DATA: rd_mux = {23'h0, rx_data_reg};
			`UX_OFF_STATUS: rd_mux = {27'h0, match_reg, rx_ovr_reg, tx_state[1],
				~q_out_valid, rx_valid_reg};
			`UX_OFF_RX_ADDR: rd_mux = {24'h0, rx_address_value};
			`UX_OFF_TX_ADDR: rd_mux = {24'h0, tx_address_value};
			`UX_OFF_LINE_EXT_CONTROL: rd_mux = {28'h0, line_ext_control};
			`UX_OFF_PROT: rd_mux = {29'h0, access_protection_level};
			`UX_OFF_TIMEOUT: rd_mux = {24'h0, bus_timeout_reload};
			`UX_OFF_PARAM: rd_mux = (param_register_present != 0) ? param_word(1'b0) : 32'h0;
			`UX_OFF_VERSION: rd_mux = (FEATURES_PRESENT != 0) ? VERSION_VALUE : 32'h0;
			`UX_OFF_TYPE: rd_mux = (FEATURES_PRESENT != 0) ? TYPE_VALUE : 32'h0;
			default: rd_mux = 32'h0;
		endcase
	end

	// Receive synchroniser and sampler
	reg rx_s1_reg;
	reg rx_s2_reg;
	reg rx_prev_reg;
	reg [1:0] rx_state;
	reg [15:0] rx_div_reg;
	reg [3:0] rx_bits_reg; // Data bits left
	reg [9:0] rx_sh_reg;
	reg rx_push; // Character completes and is stored this cycle
	reg [8:0] rx_char; // Completed character, right justified
	reg rx_done;

	// Frame completion and address filtering decision
	always @* begin
		rx_done = (rx_state == S_RUN) & (rx_div_reg == 16'h0) & (rx_bits_reg == 4'h0);
		// Bits enter at the top of the shifter LSB first, so the character sits left justified
		rx_char = nine_bit_enable ? rx_sh_reg[9:1] : {1'b0, rx_sh_reg[9:2]};
		rx_push = 1'b0;
		if (rx_done & rx_s2_reg) begin
			if (filter_eff) begin
				rx_push = ~rx_char[8] & match_reg;
			end else begin
				rx_push = 1'b1;
			end
		end
	end

	// Bus registers and hang counter
	always @(posedge ref_clk) begin
		if (rst) begin
			line_ext_control <= `UX_LCR_RST;
			rx_address_value <= `UX_ADDR_RST;
			tx_address_value <= `UX_ADDR_RST;
			access_protection_level <= `UX_PROT_RST;
			bus_timeout_reload <= TIMEOUT_DEFAULT[7:0];
			to_cnt_reg <= TIMEOUT_DEFAULT[7:0];
			prdata_reg <= 32'h0;
		end else if (ce) begin
			// Read data is ready before the access phase begins
			if (setup) begin
				prdata_reg <= (pwrite | ~prot_ok) ? 32'h0 : rd_mux;
				to_cnt_reg <= bus_timeout_reload;
			end else if (stall & ~timed_out) begin
				to_cnt_reg <= to_cnt_reg - 8'h01;
			end
			// Writes to read-only words fall to the default and do nothing
			if (wr_ok) begin
				case (paddr)
					`UX_OFF_RX_ADDR: rx_address_value <= pwdata[7:0];
					`UX_OFF_TX_ADDR: tx_address_value <= pwdata[7:0];
					`UX_OFF_PROT: access_protection_level <= pwdata[2:0];
					`UX_OFF_TIMEOUT: begin
						if (hardcoded_timeout_option == 0) begin
							bus_timeout_reload <= pwdata[7:0];
						end
					end
					default: begin
					end
				endcase
			end
			// Hardware clear of the send request loses to a software set
			if (wr_ok & (paddr == `UX_OFF_LINE_EXT_CONTROL)) begin
				line_ext_control <= pwdata[3:0];
			end else if (tx_start & send_eff) begin
				line_ext_control[`UX_LCR_SEND] <= 1'b0;
			end
		end
	end

	// Transmit shifter; address beats queued data while requested
	always @(posedge ref_clk) begin
		if (rst) begin
			tx_state <= S_IDLE;
			tx_sh_reg <= 11'h7FF;
			tx_bits_reg <= 4'h0;
			tx_div_reg <= 16'h0;
			txd_reg <= 1'b1;
		end else if (ce) begin
			case (tx_state)
				S_IDLE: begin
					txd_reg <= 1'b1;
					if (tx_start) begin
						tx_state <= S_RUN;
						tx_div_reg <= BIT_CYCLES[15:0] - 16'h1;
						if (send_eff) begin
							// Only place the transmit address register reaches the line; the read mux also returns it
							tx_sh_reg <= {1'b1, 1'b1, tx_address_value, 1'b0};
						end else if (nine_bit_enable) begin
							tx_sh_reg <= {1'b1, tx_mode ? q_out_data[8] : 1'b0,
								q_out_data[7:0], 1'b0};
						end else begin
							tx_sh_reg <= {2'b11, q_out_data[7:0], 1'b0};
						end
						tx_bits_reg <= nine_bit_enable ? 4'd10 : 4'd9;
					end
				end
				S_RUN: begin
					txd_reg <= tx_sh_reg[0];
					if (tx_div_reg != 16'h0) begin
						tx_div_reg <= tx_div_reg - 16'h1;
					end else if (tx_bits_reg == 4'h0) begin
						tx_state <= S_IDLE;
					end else begin
						tx_div_reg <= BIT_CYCLES[15:0] - 16'h1;
						tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
						tx_bits_reg <= tx_bits_reg - 4'h1;
					end
				end
				default: tx_state <= S_IDLE;
			endcase
		end
	end

	// Receiver; samples mid bit after a start edge on the synchronised line
	always @(posedge ref_clk) begin
		if (rst) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
			rx_state <= S_IDLE;
			rx_div_reg <= 16'h0;
			rx_bits_reg <= 4'h0;
			rx_sh_reg <= 10'h0;
			rx_data_reg <= 9'h0;
			rx_valid_reg <= 1'b0;
			rx_ovr_reg <= 1'b0;
			match_reg <= 1'b0;
		end else if (ce) begin
			rx_s1_reg <= rxd;
			rx_s2_reg <= rx_s1_reg;
			rx_prev_reg <= rx_s2_reg;
			case (rx_state)
				S_IDLE: begin
					if (rx_prev_reg & ~rx_s2_reg) begin
						rx_state <= S_RUN;
						rx_div_reg <= BIT_CYCLES[15:0] + (BIT_CYCLES[15:0] >> 1) - 16'h1;
						// Count data bits only; the stop bit is judged at completion
						// Mode changes mid frame garble that character, so switch while idle
						rx_bits_reg <= nine_bit_enable ? 4'd9 : 4'd8;
						rx_sh_reg <= 10'h0;
					end
				end
				S_RUN: begin
					if (rx_div_reg != 16'h0) begin
						rx_div_reg <= rx_div_reg - 16'h1;
					end else if (rx_bits_reg == 4'h0) begin
						rx_state <= S_IDLE;
					end else begin
						rx_div_reg <= BIT_CYCLES[15:0] - 16'h1;
						rx_sh_reg <= {rx_s2_reg, rx_sh_reg[9:1]};
						rx_bits_reg <= rx_bits_reg - 4'h1;
					end
				end
				default: rx_state <= S_IDLE;
			endcase
			// Address characters steer the match flag and are not stored while filtering is on
			if (rx_done & rx_s2_reg & filter_eff & rx_char[8]) begin
				match_reg <= (rx_char[7:0] == rx_address_value);
			end else if (~filter_eff) begin
				match_reg <= 1'b0;
			end
			if (rx_push) begin
				rx_data_reg <= rx_char;
				rx_ovr_reg <= rx_ovr_reg | rx_valid_reg;
			end
			// A new character wins over the read that clears the flag
			if (rx_push) begin
				rx_valid_reg <= 1'b1;
			end else if (done & ~pwrite & prot_ok & (paddr == `UX_OFF_DATA)) begin
				rx_valid_reg <= 1'b0;
			end
			if (done & ~pwrite & prot_ok & (paddr == `UX_OFF_STATUS)) begin
				rx_ovr_reg <= rx_push & rx_valid_reg;
			end
		end
	end
endmodule
`default_nettype wire

// ### ux_defs.vh
// Offsets, field positions, reset values and timing counts of the UART extension block
`ifndef UX_DEFS_VH
`define UX_DEFS_VH
`define UX_OFF_DATA 8'h00
`define UX_OFF_STATUS 8'h14
`define UX_OFF_SHADOW 8'h6C
`define UX_OFF_RX_ADDR 8'hC4
`define UX_OFF_TX_ADDR 8'hC8
`define UX_OFF_LINE_EXT_CONTROL 8'hCC
`define UX_OFF_PROT 8'hD0
`define UX_OFF_TIMEOUT 8'hD4
`define UX_OFF_PARAM 8'hF4
`define UX_OFF_VERSION 8'hF8
`define UX_OFF_TYPE 8'hFC
`define UX_LCR_NINE 0
`define UX_LCR_MATCH 1
`define UX_LCR_SEND 2
`define UX_LCR_MODE 3
`define UX_LCR_RST 4'h0
`define UX_ADDR_RST 8'h00
`define UX_PROT_RST 3'h0
`define UX_TO_RST 8'hFF
`define UX_PAR_FIFO_LSB 16
`define UX_PAR_FEAT_LSB 4
`define UX_PAR_BUS_32 2'h2
`define UX_CLK_MHZ 100
`define UX_BIT_TIME_NS 8680
`define UX_BIT_CYCLES ((`UX_BIT_TIME_NS * `UX_CLK_MHZ) / 1000)
`endif

// ### ux_fifo.v
// Parameterised FIFO with valid/ready handshakes on both sides
`timescale 1ns/1ns
`default_nettype none
module ux_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
	reg [AW-1:0] wr_reg; // Write pointer
	reg [AW-1:0] rd_reg; // Read pointer
	reg [AW:0] cnt_reg; // Fill level
	wire push;
	wire pop;

	// Full and empty come straight from the fill level
	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointers wrap at DEPTH so non power of two depths also work
	always @(posedge clk) begin
		if (rst) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (push) begin
				mem[wr_reg] <= in_data;
				wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
			end
			if (push & ~pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop & ~push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### ux_checker.sv
// Checker for the bus and line behaviour of the nine-bit UART extension
`timescale 1ns/1ns
`default_nettype none
module ux_checker #(
	parameter [31:0] VERSION_VALUE = 32'h0,
	parameter [31:0] TYPE_VALUE = 32'h0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0] pprot,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic rxd,
	input wire logic txd
);
	logic [2:0] lvl; // Mirror of the protection level, updated only by granted writes
	wire acc = psel && penable && pready; // Completing access phase
	wire rd_ok = acc && !pwrite && !pslverr; // Read that was granted
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Level mirror
	always @(posedge ref_clk) begin
		if (rst) begin
			lvl <= 3'h0;
		end else if (acc && pwrite && paddr == 8'hD0 && !pslverr) begin
			lvl <= pwdata[2:0];
		end
	end
	a_ext_upper_zero: assert property (rd_ok && paddr == 8'hCC |-> prdata[31:4] == 28'h0)
		else $error("extended control upper bits not zero");
	a_param_codes: assert property (rd_ok && paddr == 8'hF4 |->
		prdata[23:16] == 8'h01 && prdata[1:0] == 2'h2)
		else $error("parameter register codes wrong");
	a_version_fixed: assert property (rd_ok && paddr == 8'hF8 |-> prdata == VERSION_VALUE)
		else $error("version register wrong");
	a_type_fixed: assert property (rd_ok && paddr == 8'hFC |-> prdata == TYPE_VALUE)
		else $error("type register wrong");
	a_ro_write_ok: assert property (acc && pwrite && paddr[7:4] == 4'hF && pprot == 3'h7 |-> !pslverr)
		else $error("write to read-only register errored");
	a_prot_refuse: assert property (acc && ((pprot & lvl) != lvl) |->
		pslverr && (pwrite || prdata == 32'h0))
		else $error("under-privileged access not refused");
	a_prot_grant: assert property (acc && !pwrite && ((pprot & lvl) == lvl) |-> !pslverr)
		else $error("privileged read refused");
	// Bench runs 8-cycle bits; reload default 255 gives at most 255 wait cycles
	a_stall_bound: assert property (psel && penable && !pready |-> ##[1:260] pready)
		else $error("stalled transfer never ended");
	a_bit_stable: assert property ($changed(txd) |=> $stable(txd)[*7])
		else $error("serial bit shorter than bit time");
endmodule
bind ux_uart_ext ux_checker #(.VERSION_VALUE(VERSION_VALUE), .TYPE_VALUE(TYPE_VALUE)) chk_i (
	.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pprot(pprot), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .rxd(rxd), .txd(txd));
`default_nettype wire

// ### ux_node.sv
// Remote multidrop node: sends and decodes nine-bit frames
`timescale 1ns/1ns
`default_nettype none
module ux_node #(
	parameter int BIT = 8
) (
	input wire logic ref_clk,
	input wire logic txd,
	output logic rxd
);
	logic [8:0] got = 9'h000; // Last decoded character
	logic [8:0] sh = 9'h000; // Decoder shift register
	int n_rx = 0; // Characters decoded so far
	initial rxd = 1'b1; // Line idles at mark
	// Decoder: centre sampling, nine data bits LSB first
	always begin
		@(negedge txd);
		repeat (BIT + BIT / 2) @(posedge ref_clk);
		for (int i = 0; i < 9; i++) begin
			sh[i] = txd;
			repeat (BIT) @(posedge ref_clk);
		end
		got = sh;
		n_rx++;
	end
	// Sender: start, nine data bits, stop, one idle bit so frames never touch
	task send(input logic [8:0] ch);
		logic [11:0] fr;
		fr = {2'b11, ch, 1'b0};
		@(posedge ref_clk);
		for (int i = 0; i < 12; i++) begin
			rxd <= fr[i];
			repeat (BIT) @(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the nine-bit UART extension block
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam [31:0] VER = 32'h3039392A; // Arbitrary value
	localparam [31:0] TYP = 32'h13579BDF; // Arbitrary value
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1; // Dropped low once to check that a frozen block ignores the bus
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] pprot = 3'h0;
	wire pready, pslverr, txd, rxd;
	wire [31:0] prdata;
	int n_fail = 0;
	int total_checks = 0;
	int wt; // Wait cycles of the last access
	logic [31:0] rd; // Read data of the last access
	logic er; // Error response of the last access
	ux_uart_ext #(.BIT_CYCLES(8), .VERSION_VALUE(VER), .TYPE_VALUE(TYP)) DUT (
		.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .rxd(rxd), .txd(txd));
	// Node default bit time matches the BIT_CYCLES override above
	ux_node node (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
	initial forever #5 ref_clk = ~ref_clk;
	task stop_test;
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One transfer; request held until the edge where pready is high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pprot <= p;
		@(posedge ref_clk);
		penable <= 1'b1;
		wt = 0;
		@(negedge ref_clk);
		while (pready !== 1'b1 && wt < 400) begin
			wt++;
			@(negedge ref_clk);
		end
		if (wt >= 400) begin
			n_fail++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 3'h7);
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 3'h7);
		chk(nm, e, rd);
	endtask
	// Bounded wait for the node to decode c characters
	task rx_wait(input int c);
		for (int k = 0; k < 2000 && node.n_rx != c; k++) @(posedge ref_clk);
		if (node.n_rx != c) begin
			n_fail++;
			stop_test();
		end
	endtask
	task t_reset;
		rdc("ext ctl reset", 8'hCC, 32'h0);
		rdc("reload reset", 8'hD4, 32'hFF);
		wr(8'hCC, 32'hFFFFFFF3);
		rdc("ext ctl upper", 8'hCC, 32'h3);
	endtask
	task t_addr_tx;
		wr(8'hCC, 32'h1);
		wr(8'hC8, 32'hA5);
		wr(8'hCC, 32'h5);
		rx_wait(1);
		chk("address char", 9'h1A5, node.got);
		rdc("send cleared", 8'hCC, 32'h1);
		wr(8'h00, 32'h3C);
		rx_wait(2);
		chk("data char", 9'h03C, node.got);
	endtask
	task t_mode1;
		wr(8'hCC, 32'h9);
		wr(8'h00, 32'h155);
		rx_wait(3);
		chk("nine-bit holding", 9'h155, node.got);
		wr(8'hCC, 32'hD);
		wr(8'h00, 32'h042);
		rx_wait(4);
		chk("send ignored", 9'h042, node.got);
	endtask
	task t_filter;
		wr(8'hC4, 32'h21);
		wr(8'hCC, 32'h3);
		node.send(9'h0AA);
		node.send(9'h120);
		node.send(9'h0BB);
		node.send(9'h121);
		node.send(9'h0CC);
		rdc("filter status", 8'h14, 32'h13);
		rdc("filtered data", 8'h00, 32'h0CC);
		wr(8'hCC, 32'h1);
		node.send(9'h1AB);
		rdc("raw char", 8'h00, 32'h1AB);
	endtask
	// A write made while the clock enable is low must leave the register alone
	task t_freeze;
		@(posedge ref_clk);
		ce <= 1'b0;
		wr(8'hC4, 32'h77);
		@(posedge ref_clk);
		ce <= 1'b1;
		rdc("frozen write", 8'hC4, 32'h21);
	endtask
	task t_ident;
		logic [7:0] ad[3];
		logic [31:0] ex[3];
		ad = '{8'hF4, 8'hF8, 8'hFC};
		ex = '{32'h00010002, VER, TYP};
		for (int i = 0; i < 3; i++) begin
			wr(ad[i], 32'hFFFFFFFF);
			chk("read-only write err", 1'b0, er);
			rdc("identity", ad[i], ex[i]);
		end
	endtask
	task t_prot;
		wr(8'hD0, 32'h5);
		apb(1'b0, 8'hCC, 32'h0, 3'h1);
		chk("prot refused", 1'b1, er);
		chk("prot data", 32'h0, rd);
		apb(1'b0, 8'hCC, 32'h0, 3'h5);
		chk("prot granted", 1'b0, er);
		wr(8'hD0, 32'h0);
	endtask
	// Fill the transmit queue until a write times out, then drain it
	task t_timeout;
		wr(8'hD4, 32'h4);
		rdc("reload written", 8'hD4, 32'h4);
		for (int k = 0; k < 12; k++) begin
			wr(8'h00, k);
			if (er === 1'b1) break;
		end
		chk("stall error", 1'b1, er);
		chk("stall cycles", 32'd4, wt);
		rd = 32'h0;
		for (int k = 0; k < 2000 && rd[1] !== 1'b1; k++) apb(1'b0, 8'h14, 32'h0, 3'h7);
		chk("queue drained", 1'b1, rd[1]);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_addr_tx();
		t_mode1();
		t_filter();
		t_freeze();
		t_ident();
		t_prot();
		t_timeout();
		stop_test();
	end
endmodule
`default_nettype wire
